// >>> design/i2c_bit_counter_irq_enable.sv
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/1ps
// Operation
// - During a frame the counter field reads the number of bits still to transfer.
// - In bus format code 000 means 9 bits and codes 001 to 111 mean 2 to 8 bits.
// - In clocked serial format code 000 means 8 bits and codes 001 to 111 mean 1 to 7 bits.
// - The field returns to 000 by itself when a frame, acknowledge included, ends.
// - Power-on reset and standby clear the field.
// - A detected stop condition loads the field with 111.
// - Setting the soft reset bit clears the field.
// - The transmit-empty request is its enable ANDed with the transmit-data-empty flag.
// - Transmit-end request rises at the ninth SCL rise with data empty in bus format, at the last rise of a clocked frame, and falls with flag or enable.
// - Receive request is its enable ANDed with the receive-full flag.
// - NACK request is its enable ANDed with the NACK flag or arbitration-lost flag.
// - The interrupt enable register is 00 after reset.
// - Soft reset resets serial control logic but keeps software registers.
module i2c_bit_counter_irq_enable (
	input wire logic mclk, // 20 MHz system clock
	input wire logic reset, // Async reset, active high
	input wire logic [i2c_bc_pkg::ADDR_W-1:0] regAddr, // Register index
	input wire logic [i2c_bc_pkg::DATA_W-1:0] regWrData, // Write data
	input wire logic regWr, // Write strobe
	input wire logic regRd, // Read strobe
	output logic [i2c_bc_pkg::DATA_W-1:0] regRdData, // Read data, cycle after strobe
	input wire logic sclIn, // SCL pin level
	input wire logic sdaIn, // SDA pin level
	input wire logic standby, // Module standby
	input wire logic txDataEmptyFlag, // Transmit data empty
	input wire logic rxDataFullFlag, // Receive data full
	input wire logic nackReceivedFlag, // NACK received
	input wire logic arbLostOverrunFlag, // Arbitration lost / overrun
	input wire logic txDataWritten, // Pulse: transmit data written
	output logic lsbFirst, // Bit order select
	output logic txEmptyIrq, // Transmit empty request
	output logic txEndIrq, // Transmit end request
	output logic rxFullIrq, // Receive full request
	output logic nackIrq, // NACK / arbitration request
	output logic eventIrq // Masked event summary
);
	import i2c_bc_pkg::*;

	// Pin synchronisers and edge finders
	logic [1:0] pinLevel;
	logic [1:0] pinRise;
	logic [1:0] pinFall;
	logic sclLevel;
	logic sclRise;
	logic sdaRise;
	logic sdaFall;

	pin_sync #(
		.W(2)
	) u_pin_sync (
		.mclk(mclk),
		.reset(reset),
		.din({sdaIn, sclIn}),
		.level(pinLevel),
		.rise(pinRise),
		.fall(pinFall)
	);

	assign sclLevel = pinLevel[0];
	assign sclRise = pinRise[0];
	assign sdaRise = pinRise[1];
	assign sdaFall = pinFall[1];

	// Software registers
	logic lsbFirst_r;
	logic lsbFirst_nxt;
	logic [DATA_W-1:0] ier_r;
	logic [DATA_W-1:0] ier_nxt;
	logic softReset_r;
	logic softReset_nxt;
	logic syncFormat_r;
	logic syncFormat_nxt;
	logic txEndFlag_r;
	logic txEndFlag_nxt;
	logic [DATA_W-1:0] rdData_r;
	logic [DATA_W-1:0] rdData_nxt;

	// Frame counter state
	frame_state_t frameState_r;
	frame_state_t frameState_nxt;
	logic [2:0] bitCode_r;
	logic [2:0] bitCode_nxt;
	logic [3:0] remain_r;
	logic [3:0] remain_nxt;
	// Length latched at frame start, so the ninth clock is known after rewrites
	logic [3:0] frameLenAtStart_r;
	logic [3:0] frameLenAtStart_nxt;

	logic wrMode;
	logic wrIer;
	logic wrCtrl;
	logic wrStat;
	logic ctrlClear;
	logic startSeen;
	logic stopSeen;
	logic frameDone;
	logic ninthClock;
	logic [3:0] frameLen;
	logic [3:0] curRemain;
	logic [3:0] nextRemain;
	logic [2:0] shownCode;
	logic [DATA_W-1:0] modeRead;

	ev_status_if ev ();

	event_status u_event_status (
		.mclk(mclk),
		.reset(reset),
		.ev(ev)
	);

	// Decode
	assign wrMode = regWr && (regAddr == OFS_MODE);
	assign wrIer = regWr && (regAddr == OFS_IER);
	assign wrCtrl = regWr && (regAddr == OFS_CTRL);
	assign wrStat = regWr && (regAddr == OFS_STAT);

	// Soft reset and standby only hold the frame logic, never the registers
	assign ctrlClear = softReset_r | standby;

	// Bus conditions only exist in bus format
	assign startSeen = ~syncFormat_r & sclLevel & sdaFall;
	assign stopSeen = ~syncFormat_r & sclLevel & sdaRise;

	// Frame length from the stored code
	always_comb begin
		if (syncFormat_r) begin
			frameLen = (bitCode_r == BC_ZERO) ? SYNC_FULL_LEN : {1'b0, bitCode_r};
		end else begin
			frameLen = (bitCode_r == BC_ZERO) ? I2C_FULL_LEN : {1'b0, bitCode_r} + 4'h1;
		end
	end

	// First SCL rise of a frame counts as its first bit
	always_comb begin
		curRemain = (frameState_r == FRAME_BUSY) ? remain_r : frameLen;
		nextRemain = curRemain - 4'h1;
		frameDone = sclRise && !ctrlClear && !startSeen && !stopSeen && (nextRemain == 4'h0);
		ninthClock = frameDone && !syncFormat_r && (curRemain == 4'h1)
			&& (frameState_r == FRAME_BUSY ? frameLenAtStart_r == I2C_FULL_LEN
			: frameLen == I2C_FULL_LEN);
	end

	always_comb begin
		frameState_nxt = frameState_r;
		bitCode_nxt = bitCode_r;
		remain_nxt = remain_r;
		frameLenAtStart_nxt = frameLenAtStart_r;
		if (wrMode && !regWrData[MODE_WRITE_PROT]) begin
			bitCode_nxt = regWrData[2:0];
		end
		if (ctrlClear) begin
			frameState_nxt = FRAME_IDLE;
			bitCode_nxt = BC_ZERO;
			remain_nxt = 4'h0;
		end else if (stopSeen) begin
			frameState_nxt = FRAME_IDLE;
			bitCode_nxt = BC_AFTER_STOP;
			remain_nxt = 4'h0;
		end else if (startSeen) begin
			frameState_nxt = FRAME_IDLE;
			remain_nxt = 4'h0;
		end else if (sclRise) begin
			if (frameState_r == FRAME_IDLE) begin
				frameLenAtStart_nxt = frameLen;
			end
			if (nextRemain == 4'h0) begin
				frameState_nxt = FRAME_IDLE;
				bitCode_nxt = BC_ZERO;
				remain_nxt = 4'h0;
			end else begin
				frameState_nxt = FRAME_BUSY;
				remain_nxt = nextRemain;
			end
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			frameState_r <= FRAME_IDLE;
			bitCode_r <= BC_ZERO;
			remain_r <= 4'h0;
			frameLenAtStart_r <= 4'h0;
		end else begin
			frameState_r <= frameState_nxt;
			bitCode_r <= bitCode_nxt;
			remain_r <= remain_nxt;
			frameLenAtStart_r <= frameLenAtStart_nxt;
		end
	end

	// Field shows bits left while busy, the stored code otherwise
	always_comb begin
		if (frameState_r == FRAME_IDLE) begin
			shownCode = bitCode_r;
		end else if (syncFormat_r) begin
			shownCode = (remain_r == SYNC_FULL_LEN) ? BC_ZERO : remain_r[2:0];
		end else begin
			shownCode = (remain_r == I2C_FULL_LEN) ? BC_ZERO : 3'(remain_r - 4'h1);
		end
	end

	// Write protect reads as 1 and the reserved bits as printed
	assign modeRead = MODE_FIXED_ONES | {lsbFirst_r, 4'h0, shownCode};

	// Software registers, untouched by soft reset
	always_comb begin
		lsbFirst_nxt = lsbFirst_r;
		ier_nxt = ier_r;
		softReset_nxt = softReset_r;
		syncFormat_nxt = syncFormat_r;
		txEndFlag_nxt = txEndFlag_r;
		if (wrMode) begin
			lsbFirst_nxt = regWrData[MODE_LSB_FIRST];
		end
		if (wrIer) begin
			// Received acknowledge belongs to logic outside this block
			ier_nxt = regWrData & ~(8'h01 << IER_ACK_RECEIVED);
		end
		if (wrCtrl) begin
			softReset_nxt = regWrData[CTRL_SOFT_RESET];
			syncFormat_nxt = regWrData[CTRL_SYNC_FORMAT];
		end
		if ((wrStat && !regWrData[STAT_TX_END]) || txDataWritten) begin
			txEndFlag_nxt = 1'b0;
		end
		// Set after clear so a coincident event wins
		if ((ninthClock && txDataEmptyFlag) || (frameDone && syncFormat_r)) begin
			txEndFlag_nxt = 1'b1;
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			lsbFirst_r <= MODE_RESET[MODE_LSB_FIRST];
			ier_r <= IER_RESET;
			softReset_r <= CTRL_RESET[CTRL_SOFT_RESET];
			syncFormat_r <= CTRL_RESET[CTRL_SYNC_FORMAT];
			txEndFlag_r <= 1'b0;
		end else begin
			lsbFirst_r <= lsbFirst_nxt;
			ier_r <= ier_nxt;
			softReset_r <= softReset_nxt;
			syncFormat_r <= syncFormat_nxt;
			txEndFlag_r <= txEndFlag_nxt;
		end
	end

	// Read path, data valid only in the cycle after the strobe
	always_comb begin
		rdData_nxt = UNMAPPED_READ;
		if (regRd) begin
			unique case (regAddr)
				OFS_MODE: begin
					rdData_nxt = modeRead;
				end
				OFS_IER: begin
					rdData_nxt = ier_r;
				end
				OFS_CTRL: begin
					rdData_nxt = {6'h00, softReset_r, syncFormat_r};
				end
				OFS_STAT: begin
					rdData_nxt = {1'b0, txEndFlag_r, 6'h00};
				end
				OFS_EVSTAT: begin
					rdData_nxt = {4'h0, ev.status};
				end
				OFS_EVMASK: begin
					rdData_nxt = {4'h0, ev.mask};
				end
				default: begin
					rdData_nxt = UNMAPPED_READ;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			rdData_r <= UNMAPPED_READ;
		end else begin
			rdData_r <= rdData_nxt;
		end
	end

	// Event status feed
	always_comb begin
		ev.evSet = '0;
		ev.evSet[EV_FRAME_DONE] = frameDone;
		ev.evSet[EV_STOP] = stopSeen;
		ev.evSet[EV_START] = startSeen;
		ev.evSet[EV_TX_END] = txEndFlag_nxt & ~txEndFlag_r;
		ev.rdClear = regRd && (regAddr == OFS_EVSTAT);
		ev.maskWr = regWr && (regAddr == OFS_EVMASK);
		ev.maskWrData = regWrData[EV_W-1:0];
	end

	// Requests follow their flags directly so clearing withdraws at once
	assign txEmptyIrq = ier_r[IER_TX_EMPTY] & txDataEmptyFlag;
	assign txEndIrq = ier_r[IER_TX_END] & txEndFlag_r;
	assign rxFullIrq = ier_r[IER_RX_FULL] & rxDataFullFlag;
	assign nackIrq = ier_r[IER_NACK] & (nackReceivedFlag | arbLostOverrunFlag);
	assign eventIrq = ev.irq;
	assign lsbFirst = lsbFirst_r;
	assign regRdData = rdData_r;
endmodule

// >>> design/i2c_bc_pkg.sv
package i2c_bc_pkg;
	// Register map, one byte per index
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;
	localparam logic [ADDR_W-1:0] OFS_MODE = 3'h0;
	localparam logic [ADDR_W-1:0] OFS_IER = 3'h1;
	localparam logic [ADDR_W-1:0] OFS_CTRL = 3'h2;
	localparam logic [ADDR_W-1:0] OFS_STAT = 3'h3;
	localparam logic [ADDR_W-1:0] OFS_EVSTAT = 3'h4;
	localparam logic [ADDR_W-1:0] OFS_EVMASK = 3'h5;

	// Reset values
	localparam logic [DATA_W-1:0] MODE_RESET = 8'h38;
	localparam logic [DATA_W-1:0] IER_RESET = 8'h00;
	localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
	localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;

	// Bus mode control fields
	localparam int MODE_LSB_FIRST = 7;
	localparam int MODE_WRITE_PROT = 3;
	localparam logic [DATA_W-1:0] MODE_FIXED_ONES = 8'h38;

	// Interrupt enable control fields
	localparam int IER_TX_EMPTY = 7;
	localparam int IER_TX_END = 6;
	localparam int IER_RX_FULL = 5;
	localparam int IER_NACK = 4;
	localparam int IER_ACK_RECEIVED = 1;

	// Control register two fields
	localparam int CTRL_SOFT_RESET = 1;
	localparam int CTRL_SYNC_FORMAT = 0;

	// Status register fields
	localparam int STAT_TX_END = 6;

	// Event status / mask fields
	localparam int EV_W = 4;
	localparam int EV_FRAME_DONE = 0;
	localparam int EV_STOP = 1;
	localparam int EV_START = 2;
	localparam int EV_TX_END = 3;

	// Bit counter codes and frame lengths
	localparam logic [2:0] BC_ZERO = 3'h0;
	localparam logic [2:0] BC_AFTER_STOP = 3'h7;
	localparam logic [3:0] I2C_FULL_LEN = 4'h9;
	localparam logic [3:0] SYNC_FULL_LEN = 4'h8;

	localparam int SYNC_STAGES = 2;

	typedef enum logic [0:0] {
		FRAME_IDLE = 1'b0,
		FRAME_BUSY = 1'b1
	} frame_state_t;
endpackage

// >>> design/ev_status_if.sv
`timescale 1ns/1ps
interface ev_status_if;
	import i2c_bc_pkg::*;
	logic [EV_W-1:0] evSet;
	logic rdClear;
	logic maskWr;
	logic [EV_W-1:0] maskWrData;
	logic [EV_W-1:0] status;
	logic [EV_W-1:0] mask;
	logic irq;
	modport store (
		input evSet, rdClear, maskWr, maskWrData,
		output status, mask, irq
	);
	modport user (
		output evSet, rdClear, maskWr, maskWrData,
		input status, mask, irq
	);
endinterface

// >>> design/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
	parameter int W = 2
) (
	input wire logic mclk, // System clock
	input wire logic reset, // Async reset, active high
	input wire logic [W-1:0] din, // Asynchronous pins
	output logic [W-1:0] level, // Synchronised level
	output logic [W-1:0] rise, // One-cycle rising edge
	output logic [W-1:0] fall // One-cycle falling edge
);
	import i2c_bc_pkg::*;

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic meta_r;
			logic meta_nxt;
			logic sync_r;
			logic sync_nxt;
			logic prev_r;
			logic prev_nxt;
			always_comb begin
				meta_nxt = din[i];
				sync_nxt = meta_r;
				prev_nxt = sync_r;
			end
			// Idle bus lines are high, so reset to 1 avoids a false edge
			always_ff @(posedge mclk or posedge reset) begin
				if (reset) begin
					meta_r <= 1'b1;
					sync_r <= 1'b1;
					prev_r <= 1'b1;
				end else begin
					meta_r <= meta_nxt;
					sync_r <= sync_nxt;
					prev_r <= prev_nxt;
				end
			end
			assign level[i] = sync_r;
			assign rise[i] = sync_r & ~prev_r;
			assign fall[i] = ~sync_r & prev_r;
		end
	endgenerate
endmodule

// >>> design/event_status.sv
`timescale 1ns/1ps
module event_status (
	input wire logic mclk, // System clock
	input wire logic reset, // Async reset, active high
	ev_status_if.store ev // Event set, clear and mask
);
	import i2c_bc_pkg::*;

	logic [EV_W-1:0] status_r;
	logic [EV_W-1:0] status_nxt;
	logic [EV_W-1:0] mask_r;
	logic [EV_W-1:0] mask_nxt;

	// Set wins over the read clear so no event is lost
	always_comb begin
		status_nxt = (ev.rdClear ? '0 : status_r) | ev.evSet;
		mask_nxt = ev.maskWr ? ev.maskWrData : mask_r;
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			status_r <= '0;
			mask_r <= '0;
		end else begin
			status_r <= status_nxt;
			mask_r <= mask_nxt;
		end
	end

	assign ev.status = status_r;
	assign ev.mask = mask_r;
	assign ev.irq = |(status_r & mask_r);
endmodule

// >>> test/link_partner.sv
`timescale 1ns/1ps
module link_partner (
	output logic scl, // Bus clock
	output logic sda // Bus data
);
	initial begin
		scl = 1'b1; // Pulled up while idle
		sda = 1'b1;
	end
	// Clock parked low so software may load a count
	task automatic hold();
		#7 scl = 1'b0;
		#200;
	endtask
	// Data moves only while the clock is low
	task automatic bitClk();
		scl = 1'b0;
		#100 sda = ~sda;
		#100 scl = 1'b1;
		#200;
	endtask
	task automatic stopCond();
		scl = 1'b0;
		#100 sda = 1'b0;
		#100 scl = 1'b1;
		#200 sda = 1'b1;
		#200;
	endtask
endmodule

// >>> test/i2c_bc_props.sv
`timescale 1ns/1ps
module i2c_bc_props
	import i2c_bc_pkg::*;
(
	input wire logic mclk, // Clock
	input wire logic reset, // Reset
	input wire logic [i2c_bc_pkg::ADDR_W-1:0] regAddr, // Index
	input wire logic [i2c_bc_pkg::DATA_W-1:0] regWrData, // Data
	input wire logic regWr, // Write
	input wire logic regRd, // Read
	input wire logic [i2c_bc_pkg::DATA_W-1:0] regRdData, // Read data
	input wire logic sclIn, // Clock pin
	input wire logic standby, // Standby
	input wire logic txDataEmptyFlag, // Flag
	input wire logic rxDataFullFlag, // Flag
	input wire logic nackReceivedFlag, // Flag
	input wire logic arbLostOverrunFlag, // Flag
	input wire logic txDataWritten, // Pulse
	input wire logic txEmptyIrq, // Request
	input wire logic txEndIrq, // Request
	input wire logic rxFullIrq, // Request
	input wire logic nackIrq // Request
);
	logic [7:0] ierSh;
	logic [7:0] sclHist;
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			ierSh <= 8'h00;
			sclHist <= 8'hff;
		end else begin
			if (regWr && regAddr == OFS_IER) ierSh <= regWrData;
			sclHist <= {sclHist[6:0], sclIn};
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	sequence ierRead;
		regRd && regAddr == OFS_IER;
	endsequence
	// Wide window so no rise is still in the synchroniser
	sequence sclQuiet;
		sclHist == 8'hff || sclHist == 8'h00;
	endsequence
	tx_empty_a: assert property (txEmptyIrq == (ierSh[IER_TX_EMPTY] && txDataEmptyFlag))
		else $error("transmit empty request wrong");
	rx_full_a: assert property (rxFullIrq == (ierSh[IER_RX_FULL] && rxDataFullFlag))
		else $error("receive request wrong");
	nack_req_a: assert property (nackIrq == (ierSh[IER_NACK] &&
		(nackReceivedFlag || arbLostOverrunFlag))) else $error("nack request wrong");
	tx_end_off_a: assert property (!ierSh[IER_TX_END] |-> !txEndIrq)
		else $error("transmit end request while disabled");
	tx_end_clear_a: assert property (txDataWritten ##0 sclQuiet |=> !txEndIrq)
		else $error("transmit end request not withdrawn");
	tx_end_set_a: assert property ($rose(txEndIrq) && !$past(regWr) |->
		$past(txDataEmptyFlag)) else $error("transmit end without empty data");
	ier_read_a: assert property (ierRead |=> regRdData == ($past(ierSh) & 8'hfd))
		else $error("enable register readback wrong");
	standby_clr_a: assert property (standby && $past(standby) && regRd &&
		regAddr == OFS_MODE |=> regRdData[2:0] == BC_ZERO) else $error("count not cleared");
endmodule
bind i2c_bit_counter_irq_enable i2c_bc_props i_props (.*);

// >>> test/i2c_bit_counter_irq_enable_test.sv
`timescale 1ns/1ps
module i2c_bit_counter_irq_enable_test;
	import i2c_bc_pkg::*;
	logic mclk, reset, regWr, regRd, standby, txDataWritten;
	logic [ADDR_W-1:0] regAddr;
	logic [DATA_W-1:0] regWrData, regRdData, v;
	logic [3:0] flags;
	logic scl, sda, lsbFirst, txEmptyIrq, txEndIrq, rxFullIrq, nackIrq, eventIrq;
	int fail_count = 0;
	int checks = 0;
	link_partner i_bus (.scl(scl), .sda(sda));
	i2c_bit_counter_irq_enable i_dut (.mclk(mclk), .reset(reset), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
		.sclIn(scl), .sdaIn(sda), .standby(standby), .txDataEmptyFlag(flags[3]),
		.rxDataFullFlag(flags[2]), .nackReceivedFlag(flags[1]),
		.arbLostOverrunFlag(flags[0]), .txDataWritten(txDataWritten), .lsbFirst(lsbFirst),
		.txEmptyIrq(txEmptyIrq), .txEndIrq(txEndIrq), .rxFullIrq(rxFullIrq),
		.nackIrq(nackIrq), .eventIrq(eventIrq));
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic results();
		$display("checks=%0d fail_count=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge mclk);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge mclk);
		regWr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [2:0] a);
		@(posedge mclk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge mclk);
		regRd <= 1'b0;
		#1 v = regRdData;
	endtask
	task automatic t_reset();
		rd(OFS_IER);
		check(v, IER_RESET);
		rd(OFS_MODE);
		check(v, MODE_RESET);
		check(lsbFirst, 8'h00);
		// Write protect set: bit order taken, count kept
		wr(OFS_MODE, 8'h8f);
		check(lsbFirst, 8'h01);
		rd(OFS_MODE);
		check(v, MODE_RESET | 8'h80);
		wr(OFS_MODE, 8'h00);
		check(lsbFirst, 8'h00);
		wr(3'h7, 8'hff);
		rd(3'h7);
		check(v, UNMAPPED_READ);
	endtask
	task automatic t_irq();
		wr(OFS_IER, 8'hb0);
		for (int f = 0; f < 16; f++) begin
			@(posedge mclk) flags <= f[3:0];
			@(posedge mclk);
			#1 check({txEmptyIrq, rxFullIrq, nackIrq}, {f[3], f[2], f[1] | f[0]});
		end
		wr(OFS_IER, 8'h00);
		check({txEmptyIrq, rxFullIrq, nackIrq}, 8'h00);
		@(posedge mclk) flags <= 4'h8;
	endtask
	// One frame per code, each read back after every clock rise
	task automatic t_frames(input logic fmt);
		int len;
		logic [7:0] fld;
		wr(OFS_CTRL, {7'h0, fmt});
		wr(OFS_EVMASK, {7'h0, ~fmt});
		wr(OFS_IER, 8'h40);
		for (int c = 0; c < 8; c++) begin
			i_bus.hold();
			wr(OFS_MODE, c[7:0]);
			rd(OFS_MODE);
			check(v, MODE_RESET | c[7:0]);
			len = fmt ? (c == 0 ? 8 : c) : (c == 0 ? 9 : c + 1);
			for (int k = 1; k <= len; k++) begin
				i_bus.bitClk();
				repeat (2) @(posedge mclk);
				rd(OFS_MODE);
				fld = (k < len) ? 8'(fmt ? len - k : len - k - 1) : 8'h00;
				check(v, MODE_RESET | fld);
			end
			if (fmt || c == 0) begin
				check(txEndIrq, 8'h01);
				wr(OFS_IER, 8'h00);
				check(txEndIrq, 8'h00);
				wr(OFS_IER, 8'h40);
				check(txEndIrq, 8'h01);
			end
			@(posedge mclk) txDataWritten <= 1'b1;
			@(posedge mclk) txDataWritten <= 1'b0;
			#1 check(txEndIrq, 8'h00);
			check(eventIrq, {7'h0, ~fmt});
			i_bus.stopCond();
			repeat (2) @(posedge mclk);
			rd(OFS_MODE);
			// Stop is refused in clocked format, but its clock rise opens an 8-bit frame
			check(v, MODE_RESET | 8'h07);
			if (fmt) begin
				wr(OFS_CTRL, 8'h03);
				wr(OFS_CTRL, 8'h01);
				rd(OFS_MODE);
				check(v, MODE_RESET);
			end
			rd(OFS_EVSTAT);
			check(v & 8'h07, fmt ? 8'h01 : 8'h03);
			check(eventIrq, 8'h00);
		end
	endtask
	task automatic t_clear();
		@(posedge mclk) standby <= 1'b1;
		@(posedge mclk);
		rd(OFS_MODE);
		check(v, MODE_RESET);
		@(posedge mclk) standby <= 1'b0;
		i_bus.hold();
		wr(OFS_MODE, 8'h05);
		wr(OFS_CTRL, 8'h02);
		rd(OFS_MODE);
		check(v, MODE_RESET);
		rd(OFS_IER);
		check(v, 8'h40);
		wr(OFS_CTRL, 8'h00);
	endtask
	initial begin
		reset = 1'b1;
		regWr = 1'b0;
		regRd = 1'b0;
		regAddr = '0;
		regWrData = '0;
		standby = 1'b0;
		txDataWritten = 1'b0;
		flags = 4'h0;
		repeat (5) @(posedge mclk);
		reset <= 1'b0;
		t_reset();
		t_irq();
		t_frames(1'b0);
		t_clear();
		t_frames(1'b1);
		results();
	end
	// A hang counts as a mismatch
	initial begin
		repeat (60000) @(posedge mclk);
		fail_count++;
		results();
	end
endmodule
